// ===== hw/dcg_map.svh
// Constants of the clock generator unit: register map, fields, resets, counts
`ifndef DCG_MAP_SVH
`define DCG_MAP_SVH
// Width of each variable PLL configuration bus and its enable bit
`define DCG_CFG_W 8
`define DCG_CFG_EN_BIT 0
// Width of a divide ratio, enough for 32:1
`define DCG_RW 6
// APB register byte offsets
`define DCG_OFF_CTRL 12'h000
`define DCG_OFF_STATUS 12'h004
`define DCG_OFF_RATIO 12'h008
// Control register: pending external port ratios, stored as ratio minus one
`define DCG_CTRL_MST_LSB 0
`define DCG_CTRL_SLV_LSB 4
`define DCG_CTRL_RESET 8'h00
// Status register fields
`define DCG_ST_LOCK_LSB 0
`define DCG_ST_CORE_LSB 4
`define DCG_ST_MON_LSB 8
`define DCG_ST_TEST_BIT 12
`define DCG_ST_RUN_BIT 13
// Ratio register fields, active divide ratios
`define DCG_RT_MST_LSB 0
`define DCG_RT_SLV_LSB 8
`define DCG_RT_SMEM_LSB 16
`define DCG_RT_AXI_LSB 24
// Settling count after power-on release; pin levels are trusted one cycle after it is reached
`define DCG_BOOT_SETTLE 2'h3
// One-hot source codes: fixed, variable a, variable b
`define DCG_SRC_FIXED 3'h1
// Divider slots
`define DCG_DIV_NUM 7
`define DCG_DIV_AXI 0
`define DCG_DIV_DMC 1
`define DCG_DIV_APB 2
`define DCG_DIV_SBUS 3
`define DCG_DIV_SMEM 4
`define DCG_DIV_SLV 5
`define DCG_DIV_MST 6
`endif

// ===== hw/dcg_pkg.sv
// Types shared by the clock generator unit
`include "dcg_map.svh"
package dcg_pkg;
  // Glitch-free switch sequence
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_DROP = 2'b01,
    SW_PICK = 2'b10
  } sw_state_t;
  // Divide ratio
  typedef logic [`DCG_RW-1:0] ratio_t;
  // Every level that arrives from a pin or a foreign clock
  typedef struct packed {
    logic [`DCG_CFG_W-1:0] test_bus_a;
    logic [`DCG_CFG_W-1:0] test_bus_b;
    logic [2:0] ref_clk;
    logic [2:0] raw_clk;
    logic [2:0] lock;
    logic ref_sel;
    logic bypass;
    logic test;
    logic axi_ratio;
    logic smc_ratio;
    logic [1:0] mem_ratio;
    logic sys_rst_n;
    logic em_enable;
  } pin_bits_t;
endpackage : dcg_pkg

// ===== hw/glitch_free_switch.sv
// Three-way glitch-free clock switch with synchronised select
`timescale 1ns/1ps
`default_nettype none
`include "dcg_map.svh"
module glitch_free_switch (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [2:0] i_src,
  input wire logic [2:0] i_select,
  input wire logic i_force_fixed,
  output logic o_clk,
  output logic [2:0] o_current
);
  import dcg_pkg::*;
  typedef struct packed {
    logic [2:0] meta;     // First select stage, read by sync only
    logic [2:0] sync;     // Settled select
    logic [2:0] prev;     // Source levels one cycle ago
    logic [2:0] active;   // Source gated onto the output
    logic [2:0] target;   // Source being switched to
    logic [2:0] current;  // Reported source
    sw_state_t state;
    logic out;
  } sw_t;
  sw_t st;
  sw_t next_st;
  logic [2:0] want;
  logic [2:0] fell;
  // Old source released on its fall, new one taken on its own fall
  always_comb begin
    want = i_force_fixed ? `DCG_SRC_FIXED : st.sync;
    fell = st.prev & ~i_src;
    next_st = st;
    next_st.meta = i_select;
    next_st.sync = st.meta;
    next_st.prev = i_src;
    unique case (st.state)
      SW_IDLE: if (want != st.current) begin
        next_st.target = want;
        next_st.state = SW_DROP;
      end
      SW_DROP: if (st.active == 3'h0 || (|(fell & st.active))) begin
        next_st.active = 3'h0;
        next_st.state = SW_PICK;
      end
      SW_PICK: if (st.target == 3'h0 || (|(fell & st.target))) begin
        next_st.active = st.target;
        next_st.current = st.target;
        next_st.state = SW_IDLE;
      end
      default: next_st.state = SW_IDLE;  // Illegal code recovers
    endcase
    // Gate only while the chosen source is low at the change
    next_st.out = |(next_st.active & i_src);
  end
  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_clk = st.out;
  assign o_current = st.current;
  sequence s_handover;
    (st.state == SW_PICK) ##1 (st.state == SW_IDLE);
  endsequence
  out_source_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_clk |-> |(o_current & $past(i_src))) else $error("output high off the reported source");
  pick_order_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_handover |-> (o_current == st.target) && !o_clk) else $error("bad source handover");
endmodule : glitch_free_switch
`default_nettype wire

// ===== hw/clock_pulse_divider.sv
// Pulse-gating clock divider with stretched falling edge
`timescale 1ns/1ps
`default_nettype none
module clock_pulse_divider #(
  parameter int RW = 6
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_run,
  input wire logic [RW-1:0] i_ratio,
  output logic o_clk,
  output logic o_clk_inv,
  output logic o_en
);
  typedef struct packed {
    logic [RW-1:0] cnt;  // Phase within the divided period
    logic [RW-1:0] gap;  // Cycles since the last enable
    logic seen;          // Counter has started
    logic had;           // An enable has been issued
    logic clk;
    logic inv;
    logic en;
  } div_t;
  div_t st;
  div_t next_st;
  logic [RW-1:0] half;
  // Enable pulse at phase zero; high phase stretched to half the period
  always_comb begin
    half = RW'((i_ratio + RW'(1)) >> 1);
    next_st = st;
    if (!i_run) begin
      next_st = '0;
      next_st.inv = 1'b1;
    end else begin
      if (!st.seen || st.cnt >= i_ratio - RW'(1)) begin
        next_st.cnt = '0;
      end else begin
        next_st.cnt = st.cnt + RW'(1);
      end
      next_st.seen = 1'b1;
      next_st.en = (next_st.cnt == '0);
      next_st.clk = (next_st.cnt < half);
      next_st.inv = !next_st.clk;
      next_st.gap = next_st.en ? '0 : st.gap + RW'(1);
      next_st.had = st.had | next_st.en;
    end
  end
  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.inv <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  assign o_clk = st.clk;
  assign o_clk_inv = st.inv;
  assign o_en = st.en;
  en_period_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_en && $past(st.had) && $past(i_run) |-> $past(st.gap) == i_ratio - RW'(1))
    else $error("enable spacing differs from ratio");
  en_phase_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_en |-> o_clk && !o_clk_inv) else $error("enable outside the high phase");
endmodule : clock_pulse_divider
`default_nettype wire

// ===== hw/dynamic_clock_generator.sv
// Clock generator unit: PLL routing, clock switches, divider tree, APB status
`timescale 1ns/1ps
`default_nettype none
`include "dcg_map.svh"
// Summary of operation
// - Variable PLL reference picked by select input
// - Bypass drives each PLL output from reference
// - Fixed PLL enabled by reset, others by bus
// - Test mode hands variable PLLs to test buses
// - PLL test mode routes clocks, locks to pins
// - Three PLL clocks and three lock flags out
// - Core and monitor clocks via glitch-free switches
// - Clock selects synchronised before use
// - Current source changes at new clock fall
// - All divided clocks come from fixed clock
// - AXI clock is core over 2 or 4
// - Memory controller clock 1:1 or 2:1
// - APB clock always AXI clock over two
// - Slave port divider also makes PLL feedback
// - Master port divider clock exported off-chip
// - Static bus clock 1:1 or 2:1 AXI
// - Static memory clock 1:1, 2:1 or 3:1
// - Inverted static memory clock also provided
// - Ratios latched at reset, never changed live
// - Divided clocks gated pulses, even mark-space
// - External ports 1:1 to 8:1, static 1:1/2:1
// - Fixed PLL used at full or unmanaged performance
module dynamic_clock_generator #(
  parameter int CFG_W = `DCG_CFG_W
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Reference clocks and PLL macro outputs
  input wire logic i_primary_ref_clock,
  input wire logic i_alt_ref_clock_a,
  input wire logic i_alt_ref_clock_b,
  input wire logic i_fixed_pll_raw,
  input wire logic i_variable_pll_a_raw,
  input wire logic i_variable_pll_b_raw,
  input wire logic i_fixed_pll_lock,
  input wire logic i_variable_pll_a_lock,
  input wire logic i_variable_pll_b_lock,
  // Configuration pins
  input wire logic i_variable_pll_ref_select,
  input wire logic i_pll_bypass_cfg,
  input wire logic i_manufacturing_test_select,
  input wire logic i_axi_ratio_cfg,
  input wire logic i_static_bus_ratio_cfg,
  input wire logic [1:0] i_static_mem_ratio_cfg,
  input wire logic i_sys_reset_n,
  input wire logic i_energy_mgmt_enable,
  input wire logic [CFG_W-1:0] i_test_cfg_bus_a,
  input wire logic [CFG_W-1:0] i_test_cfg_bus_b,
  // From the performance level controller
  input wire logic [CFG_W-1:0] i_variable_pll_a_cfg_bus,
  input wire logic [CFG_W-1:0] i_variable_pll_b_cfg_bus,
  input wire logic [2:0] i_core_clock_select,
  input wire logic [2:0] i_monitor_clock_select,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // PLL section
  output logic o_fixed_pll_en,
  output logic o_variable_pll_ref_clock,
  output logic [CFG_W-1:0] o_variable_pll_a_cfg,
  output logic [CFG_W-1:0] o_variable_pll_b_cfg,
  output logic o_fixed_pll_clock,
  output logic o_variable_pll_a_clock,
  output logic o_variable_pll_b_clock,
  output logic [2:0] o_pll_lock,
  output logic [5:0] o_pll_test_pins,
  // Clock switches
  output logic o_generated_core_clock,
  output logic o_monitor_clock,
  output logic [2:0] o_current_core_source,
  output logic [2:0] o_current_monitor_source,
  // Divider tree
  output logic o_axi_clock,
  output logic o_axi_clock_en,
  output logic o_dyn_memctl_clock,
  output logic o_dyn_memctl_clock_en,
  output logic o_apb_clock,
  output logic o_apb_clock_en,
  output logic o_static_bus_clock,
  output logic o_static_bus_clock_en,
  output logic o_static_mem_clock,
  output logic o_static_mem_clock_en,
  output logic o_static_mem_clock_delayed,
  output logic o_ext_slave_clock,
  output logic o_ext_slave_clock_en,
  output logic o_fixed_pll_feedback_clock,
  output logic o_ext_master_clock,
  output logic o_ext_master_clock_en
);
  import dcg_pkg::*;

  typedef struct packed {
    pin_bits_t meta;            // First stage, read only by sync
    pin_bits_t sync;            // Settled pin levels
    logic pll_en;               // Fixed PLL enable
    logic ref_out;              // Variable PLL reference
    logic [CFG_W-1:0] cfg_a;    // Variable PLL a configuration
    logic [CFG_W-1:0] cfg_b;    // Variable PLL b configuration
    logic [2:0] pll_clk;        // Fixed, variable a, variable b
    logic [2:0] lock;
    logic [5:0] test_pins;
    logic [1:0] boot;           // Settling count after power-on
    logic ok;                   // Pins trusted
    logic [7:0] ctrl;           // Pending external port ratios
    logic axi_sel;              // Latched ratio selects
    logic smc_sel;
    logic [1:0] mem_sel;
    logic [2:0] mst_idx;
    logic [2:0] slv_idx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_t;

  top_t st;
  top_t next_st;
  pin_bits_t pins;               // Raw pin vector
  logic run;                     // Dividers may count
  ratio_t axi_n;                 // Core to AXI ratio
  ratio_t div_n [`DCG_DIV_NUM];  // Ratio of each divider
  logic [`DCG_DIV_NUM-1:0] div_clk;
  logic [`DCG_DIV_NUM-1:0] div_inv;
  logic [`DCG_DIV_NUM-1:0] div_en;
  logic [31:0] status;           // Live status word
  logic [31:0] ratios;           // Active ratio word

  // Gather every foreign level into one vector for the synchroniser
  always_comb begin
    pins.test_bus_a = i_test_cfg_bus_a;
    pins.test_bus_b = i_test_cfg_bus_b;
    pins.ref_clk = {i_alt_ref_clock_b, i_alt_ref_clock_a, i_primary_ref_clock};
    pins.raw_clk = {i_variable_pll_b_raw, i_variable_pll_a_raw, i_fixed_pll_raw};
    pins.lock = {i_variable_pll_b_lock, i_variable_pll_a_lock, i_fixed_pll_lock};
    pins.ref_sel = i_variable_pll_ref_select;
    pins.bypass = i_pll_bypass_cfg;
    pins.test = i_manufacturing_test_select;
    pins.axi_ratio = i_axi_ratio_cfg;
    pins.smc_ratio = i_static_bus_ratio_cfg;
    pins.mem_ratio = i_static_mem_ratio_cfg;
    pins.sys_rst_n = i_sys_reset_n;
    pins.em_enable = i_energy_mgmt_enable;
  end

  // Ratios follow only the latched selects, so they hold while running
  always_comb begin
    run = st.ok && st.sync.sys_rst_n;
    axi_n = st.axi_sel ? ratio_t'(4) : ratio_t'(2);
    div_n[`DCG_DIV_AXI] = axi_n;
    div_n[`DCG_DIV_DMC] = st.axi_sel ? ratio_t'(2) : ratio_t'(1);
    div_n[`DCG_DIV_APB] = ratio_t'(axi_n << 1);
    div_n[`DCG_DIV_SBUS] = st.smc_sel ? ratio_t'(axi_n << 1) : axi_n;
    // Zero on the memory ratio pins is taken as 1:1
    div_n[`DCG_DIV_SMEM] = ratio_t'(div_n[`DCG_DIV_SBUS] *
      ((st.mem_sel == 2'h0) ? ratio_t'(1) : ratio_t'(st.mem_sel)));
    div_n[`DCG_DIV_SLV] = ratio_t'(axi_n * ratio_t'(st.slv_idx) + axi_n);
    div_n[`DCG_DIV_MST] = ratio_t'(axi_n * ratio_t'(st.mst_idx) + axi_n);
  end

  // Register views
  always_comb begin
    status = 32'h0000_0000;
    status[`DCG_ST_LOCK_LSB +: 3] = st.lock;
    status[`DCG_ST_CORE_LSB +: 3] = o_current_core_source;
    status[`DCG_ST_MON_LSB +: 3] = o_current_monitor_source;
    status[`DCG_ST_TEST_BIT] = st.sync.test;
    status[`DCG_ST_RUN_BIT] = run;
    ratios = 32'h0000_0000;
    ratios[`DCG_RT_MST_LSB +: `DCG_RW] = div_n[`DCG_DIV_MST];
    ratios[`DCG_RT_SLV_LSB +: `DCG_RW] = div_n[`DCG_DIV_SLV];
    ratios[`DCG_RT_SMEM_LSB +: `DCG_RW] = div_n[`DCG_DIV_SMEM];
    ratios[`DCG_RT_AXI_LSB +: `DCG_RW] = axi_n;
  end

  // Next state of the whole unit
  always_comb begin
    next_st = st;
    next_st.meta = pins;
    next_st.sync = st.meta;
    // Fixed PLL runs as soon as power-on reset has gone
    next_st.pll_en = 1'b1;
    next_st.ref_out = st.sync.ref_sel ? st.sync.ref_clk[1] : st.sync.ref_clk[0];
    // Test mode lets the test pins configure the variable PLLs
    next_st.cfg_a = st.sync.test ? st.sync.test_bus_a : i_variable_pll_a_cfg_bus;
    next_st.cfg_b = st.sync.test ? st.sync.test_bus_b : i_variable_pll_b_cfg_bus;
    // Bypass hands each output straight to its reference
    next_st.pll_clk = st.sync.bypass ? st.sync.ref_clk : st.sync.raw_clk;
    next_st.lock = st.sync.lock;
    next_st.test_pins = st.sync.test ? {st.pll_clk, st.lock} : 6'h00;
    // Pin levels are caught only after the synchroniser has filled
    if (!st.ok) begin
      next_st.boot = st.boot + 2'h1;
      next_st.ok = (st.boot == `DCG_BOOT_SETTLE);
    end
    // Ratios follow pins and pending register only while held in reset
    if (!run) begin
      next_st.axi_sel = st.sync.axi_ratio;
      next_st.smc_sel = st.sync.smc_ratio;
      next_st.mem_sel = st.sync.mem_ratio;
      next_st.mst_idx = st.ctrl[`DCG_CTRL_MST_LSB +: 3];
      next_st.slv_idx = st.ctrl[`DCG_CTRL_SLV_LSB +: 3];
    end
    // APB: answer is prepared in setup so the access phase needs no wait
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      next_st.pready = 1'b1;
      if (i_paddr == `DCG_OFF_CTRL) begin
        next_st.prdata = {24'h00_0000, st.ctrl};
      end else if (i_paddr == `DCG_OFF_STATUS) begin
        next_st.prdata = status;
      end else if (i_paddr == `DCG_OFF_RATIO) begin
        next_st.prdata = ratios;
      end else begin
        next_st.prdata = 32'h0000_0000;
        next_st.pslverr = 1'b1;
      end
    end
    // Write lands at the completing edge; reserved bits are dropped
    if (i_psel && i_penable && st.pready && i_pwrite && i_paddr == `DCG_OFF_CTRL) begin
      next_st.ctrl = i_pwdata[7:0] & 8'h77;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.ctrl <= `DCG_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Core switch: the fixed source is forced when management is off
  glitch_free_switch u_core_switch (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_src(st.pll_clk),
    .i_select(i_core_clock_select),
    .i_force_fixed(!st.sync.em_enable),
    .o_clk(o_generated_core_clock),
    .o_current(o_current_core_source)
  );

  // Monitor switch, independent of the core one
  glitch_free_switch u_monitor_switch (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_src(st.pll_clk),
    .i_select(i_monitor_clock_select),
    .i_force_fixed(1'b0),
    .o_clk(o_monitor_clock),
    .o_current(o_current_monitor_source)
  );

  // Divider tree, all counters phase-aligned on the fixed-domain clock
  genvar gi;
  generate
    for (gi = 0; gi < `DCG_DIV_NUM; gi = gi + 1) begin : g_div
      clock_pulse_divider #(
        .RW(`DCG_RW)
      ) u_div (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_run(run),
        .i_ratio(div_n[gi]),
        .o_clk(div_clk[gi]),
        .o_clk_inv(div_inv[gi]),
        .o_en(div_en[gi])
      );
    end
  endgenerate

  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_fixed_pll_en = st.pll_en;
  assign o_variable_pll_ref_clock = st.ref_out;
  assign o_variable_pll_a_cfg = st.cfg_a;
  assign o_variable_pll_b_cfg = st.cfg_b;
  assign o_fixed_pll_clock = st.pll_clk[0];
  assign o_variable_pll_a_clock = st.pll_clk[1];
  assign o_variable_pll_b_clock = st.pll_clk[2];
  assign o_pll_lock = st.lock;
  assign o_pll_test_pins = st.test_pins;
  assign o_axi_clock = div_clk[`DCG_DIV_AXI];
  assign o_axi_clock_en = div_en[`DCG_DIV_AXI];
  assign o_dyn_memctl_clock = div_clk[`DCG_DIV_DMC];
  assign o_dyn_memctl_clock_en = div_en[`DCG_DIV_DMC];
  assign o_apb_clock = div_clk[`DCG_DIV_APB];
  assign o_apb_clock_en = div_en[`DCG_DIV_APB];
  assign o_static_bus_clock = div_clk[`DCG_DIV_SBUS];
  assign o_static_bus_clock_en = div_en[`DCG_DIV_SBUS];
  assign o_static_mem_clock = div_clk[`DCG_DIV_SMEM];
  assign o_static_mem_clock_en = div_en[`DCG_DIV_SMEM];
  assign o_static_mem_clock_delayed = div_inv[`DCG_DIV_SMEM];
  assign o_ext_slave_clock = div_clk[`DCG_DIV_SLV];
  assign o_ext_slave_clock_en = div_en[`DCG_DIV_SLV];
  assign o_fixed_pll_feedback_clock = div_clk[`DCG_DIV_SLV];
  assign o_ext_master_clock = div_clk[`DCG_DIV_MST];
  assign o_ext_master_clock_en = div_en[`DCG_DIV_MST];

  bypass_route_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(st.sync.bypass) |-> o_fixed_pll_clock == $past(st.sync.ref_clk[0]))
    else $error("bypass does not route the primary reference");
  ref_select_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(st.sync.ref_sel) |-> o_variable_pll_ref_clock == $past(st.sync.ref_clk[1]))
    else $error("variable reference not taken from alternate a");
  test_cfg_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(st.sync.test) |-> o_variable_pll_b_cfg == $past(st.sync.test_bus_b))
    else $error("test bus does not steer variable PLL b");
  apb_ratio_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    div_n[`DCG_DIV_APB] == ratio_t'(div_n[`DCG_DIV_AXI] * ratio_t'(2)))
    else $error("APB clock is not AXI over two");
  ratio_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    run && $past(run) |-> $stable(div_n[`DCG_DIV_SLV]) && $stable(axi_n))
    else $error("ratio changed while out of reset");
  apb_answer_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_psel && !i_penable |=> o_pready) else $error("APB answer missing");
  // Dividers start together, so every APB period opens on an AXI period
  apb_align_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_apb_clock_en |-> o_axi_clock_en) else $error("APB enable off the AXI enable");
  mem_delay_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_static_mem_clock_delayed != o_static_mem_clock)
    else $error("delayed memory clock not inverted");
endmodule : dynamic_clock_generator
`default_nettype wire

// ===== test/perf_ctl_model.sv
// Performance level controller model driving the core clock select
`timescale 1ns/1ps
`default_nettype none
module perf_ctl_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [2:0] i_want,
  input wire logic [2:0] i_current,
  input wire logic [2:0] i_lock,
  output logic [2:0] o_select,
  output logic [2:0] o_seen
);
  logic [2:0] meta;
  // Source flags are foreign to this clock, so two flops first
  // A new pick waits for its PLL lock and the last switch
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 3'h0;
      o_seen <= 3'h0;
      o_select <= 3'h1;
    end else begin
      meta <= i_current;
      o_seen <= meta;
      if (o_seen == o_select && (i_want & ~i_lock) == 3'h0) begin
        o_select <= i_want;
      end
    end
  end
endmodule : perf_ctl_model
`default_nettype wire

// ===== test/test_dynamic_clock_generator.sv
// Self-checking bench of the clock generator unit
`timescale 1ns/1ps
`default_nettype none
`include "dcg_map.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_dynamic_clock_generator;
  logic i_clk, i_arst_n, i_primary_ref_clock, i_alt_ref_clock_a, i_alt_ref_clock_b;
  logic i_fixed_pll_raw, i_variable_pll_a_raw, i_variable_pll_b_raw, i_fixed_pll_lock;
  logic i_variable_pll_a_lock, i_variable_pll_b_lock, i_variable_pll_ref_select;
  logic i_pll_bypass_cfg, i_manufacturing_test_select, i_axi_ratio_cfg, i_sys_reset_n;
  logic i_static_bus_ratio_cfg, i_energy_mgmt_enable, i_psel, i_penable, i_pwrite, err;
  logic [1:0] i_static_mem_ratio_cfg;
  logic [7:0] i_test_cfg_bus_a, i_test_cfg_bus_b, o_variable_pll_a_cfg, o_variable_pll_b_cfg;
  logic [7:0] i_variable_pll_a_cfg_bus, i_variable_pll_b_cfg_bus;
  logic [2:0] i_core_clock_select, i_monitor_clock_select, want, seen, o_pll_lock;
  logic [2:0] o_current_core_source, o_current_monitor_source;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [5:0] o_pll_test_pins;
  logic o_pready, o_pslverr, o_fixed_pll_en, o_variable_pll_ref_clock, o_fixed_pll_clock;
  logic o_variable_pll_a_clock, o_variable_pll_b_clock, o_generated_core_clock, o_monitor_clock;
  logic o_axi_clock, o_axi_clock_en, o_dyn_memctl_clock, o_dyn_memctl_clock_en, o_apb_clock;
  logic o_apb_clock_en, o_static_bus_clock, o_static_bus_clock_en, o_static_mem_clock;
  logic o_static_mem_clock_en, o_static_mem_clock_delayed, o_ext_slave_clock;
  logic o_ext_slave_clock_en, o_fixed_pll_feedback_clock, o_ext_master_clock;
  logic o_ext_master_clock_en;
  int n_mismatch = 0, n_compared = 0, n;
  dynamic_clock_generator dut (.*);
  perf_ctl_model partner (.i_clk, .i_arst_n, .i_want(want), .i_current(o_current_core_source),
    .i_lock(o_pll_lock),
    .o_select(i_core_clock_select), .o_seen(seen));
  // Source clocks run well below a quarter of the sampling clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always #100 i_fixed_pll_raw = ~i_fixed_pll_raw;
  always #120 i_variable_pll_a_raw = ~i_variable_pll_a_raw;
  always #160 i_variable_pll_b_raw = ~i_variable_pll_b_raw;
  always #110 i_primary_ref_clock = ~i_primary_ref_clock;
  always #130 i_alt_ref_clock_a = ~i_alt_ref_clock_a;
  always #150 i_alt_ref_clock_b = ~i_alt_ref_clock_b;
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : apb
  function automatic logic pick(int s);
    return s == 0 ? o_axi_clock_en : s == 1 ? o_apb_clock_en : s == 2 ? o_ext_master_clock_en :
      s == 3 ? o_dyn_memctl_clock_en : s == 4 ? o_static_mem_clock_en : o_ext_slave_clock_en;
  endfunction : pick
  // Cycles between two enable pulses; a lost pulse shows up as 99
  task automatic gap(input int s, output int g);
    g = 0;
    for (int k = 0; k < 99 && pick(s) !== 1'b1; k++) @(posedge i_clk);
    do begin
      @(posedge i_clk);
      g++;
    end while (pick(s) !== 1'b1 && g < 99);
  endtask : gap
  task automatic t_ratios();
    `CHK("fixed pll enable", 1'b1, o_fixed_pll_en)
    `CHK("lock flags", 3'h7, o_pll_lock)
    apb(1'b0, `DCG_OFF_RATIO, 32'h0);
    `CHK("ratio reg", 32'h0206_0202, rd)
    gap(0, n);
    `CHK("axi gap", 2, n)
    gap(1, n);
    `CHK("apb gap", 4, n)
    gap(3, n);
    `CHK("dmc gap", 1, n)
    gap(4, n);
    `CHK("static mem gap", 6, n)
    $display("ratios test done");
  endtask : t_ratios
  task automatic t_relatch();
    apb(1'b1, `DCG_OFF_CTRL, 32'h0000_0037);
    gap(2, n);
    `CHK("master gap before reset", 2, n)
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    i_sys_reset_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_sys_reset_n <= 1'b1;
    apb(1'b0, `DCG_OFF_RATIO, 32'h0);
    `CHK("ratio after reset", 32'h0206_0810, rd)
    gap(2, n);
    `CHK("master gap 8 to 1", 16, n)
    gap(5, n);
    `CHK("slave gap 4 to 1", 8, n)
    $display("relatch test done");
  endtask : t_relatch
  task automatic t_switch();
    want <= 3'h2;
    i_monitor_clock_select <= 3'h4;
    for (int k = 0; k < 600 && o_current_core_source !== 3'h2; k++) @(posedge i_clk);
    `CHK("core source", 3'h2, o_current_core_source)
    for (int k = 0; k < 600 && o_current_monitor_source !== 3'h4; k++) @(posedge i_clk);
    `CHK("monitor source", 3'h4, o_current_monitor_source)
    apb(1'b0, `DCG_OFF_STATUS, 32'h0);
    `CHK("status sources", 7'h42, rd[10:4])
    i_energy_mgmt_enable <= 1'b0;
    for (int k = 0; k < 600 && o_current_core_source !== 3'h1; k++) @(posedge i_clk);
    `CHK("forced fixed", 3'h1, o_current_core_source)
    $display("switch test done");
  endtask : t_switch
  // Routed clocks trail their pins by the two sync flops and the output flop
  task automatic t_bypass();
    logic [3:0] hp, ha, hb;
    int nb = 0, nr = 0;
    i_pll_bypass_cfg <= 1'b1;
    i_variable_pll_ref_select <= 1'b1;
    repeat (8) @(posedge i_clk);
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk);
      {hp, ha, hb} = {hp[2:0], i_primary_ref_clock, ha[2:0], i_alt_ref_clock_a,
        hb[2:0], i_alt_ref_clock_b};
      if (k > 3 && {o_fixed_pll_clock, o_variable_pll_b_clock} !== {hp[3], hb[3]}) nb++;
      if (k > 3 && o_variable_pll_ref_clock !== ha[3]) nr++;
    end
    `CHK("ref select", 0, nr)
    `CHK("bypass", 0, nb)
    $display("bypass test done");
  endtask : t_bypass
  task automatic t_test_mode();
    i_test_cfg_bus_a <= 8'hA5;
    i_manufacturing_test_select <= 1'b1;
    for (int k = 0; k < 20 && o_variable_pll_a_cfg !== 8'hA5; k++) @(posedge i_clk);
    `CHK("test cfg a", 8'hA5, o_variable_pll_a_cfg)
    `CHK("test lock pins", 3'h7, o_pll_test_pins[2:0])
    $display("test mode test done");
  endtask : t_test_mode
  initial begin
    {i_arst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_primary_ref_clock, i_alt_ref_clock_a, i_alt_ref_clock_b, i_fixed_pll_raw} = '0;
    {i_variable_pll_a_raw, i_variable_pll_b_raw, i_variable_pll_ref_select} = '0;
    {i_pll_bypass_cfg, i_manufacturing_test_select, i_axi_ratio_cfg} = '0;
    {i_static_bus_ratio_cfg, i_test_cfg_bus_a, i_test_cfg_bus_b} = '0;
    {i_variable_pll_a_cfg_bus, i_variable_pll_b_cfg_bus} = '0;
    {i_fixed_pll_lock, i_variable_pll_a_lock, i_variable_pll_b_lock} = 3'h7;
    {i_sys_reset_n, i_energy_mgmt_enable, i_static_mem_ratio_cfg} = 4'hF;
    want = 3'h1;
    i_monitor_clock_select = 3'h1;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (12) @(posedge i_clk);
    t_ratios();
    t_relatch();
    t_switch();
    t_bypass();
    t_test_mode();
    give_verdict();
  end
endmodule : test_dynamic_clock_generator
`default_nettype wire
